// *** core/eeprom_front.sv ***
module eeprom_front
    import eeprom_front_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE = DEVICE_TYPE_DEF,
    parameter logic [TIMER_W-1:0] POWERUP_LIMIT = TIMER_W'(POWERUP_CYCLES),
    parameter logic [TIMER_W-1:0] PROGRAM_LIMIT = TIMER_W'(PROGRAM_CYCLES),
    parameter logic [FILT_W-1:0] FILTER_LIMIT = FILT_W'(FILTER_CYCLES)
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_wp,
    input wire logic i_rx_ready,
    input wire logic [7:0] i_rd_data,
    output logic o_sda_o,
    output logic o_sda_oe_n,
    output logic o_wp_pd_oe_n,
    output logic o_ready,
    output logic o_busy,
    output logic o_wr_reject,
    output select_t o_sel,
    output logic o_rx_valid,
    output rx_word_t o_rx_word,
    output logic o_rd_req
);
    logic [1:0] sync1_ff, sync2_ff, filt_ff, filt_d_ff;
    logic [FILT_W-1:0] fcnt_ff [2];
    logic wp1_ff, wp2_ff, wp_lat_ff, nxt_wp;
    logic ready_ff, busy_ff;
    logic [TIMER_W-1:0] up_cnt_ff, prog_cnt_ff;
    proto_state_t st_ff, nxt_st;
    logic [3:0] bit_ff, nxt_bit;
    logic [7:0] shift_ff, nxt_shift, tx_ff, nxt_tx;
    logic oe_n_ff, nxt_oe_n, ack_ff, nxt_ack;
    logic addr_ph_ff, nxt_addr_ph, first_ff, nxt_first;
    logic rd_ff, nxt_rd, rej_ff, nxt_rej, wrote_ff, nxt_wrote;
    logic rd_req_ff, sda_o_ff, pd_ff;
    select_t sel_ff, nxt_sel;
    rx_word_t head_ff, tail_ff, nxt_head, nxt_tail;
    logic head_v_ff, tail_v_ff, nxt_head_v, nxt_tail_v;

    wire scl = filt_ff[LINE_SCL];
    wire sda = filt_ff[LINE_SDA];
    wire scl_rise = scl & ~filt_d_ff[LINE_SCL];
    wire scl_fall = ~scl & filt_d_ff[LINE_SCL];
    wire scl_hold = scl & filt_d_ff[LINE_SCL];
    wire start_ev = ready_ff & scl_hold & ~sda & filt_d_ff[LINE_SDA];
    wire stop_ev = scl_hold & sda & ~filt_d_ff[LINE_SDA];
    wire byte_end = st_ff == S_RECV && scl_fall && bit_ff == BYTE_BITS;
    wire buf_ready = ~tail_v_ff;
    wire type_match = shift_ff[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEVICE_TYPE;
    wire addr_ok = type_match & ~busy_ff;
    wire data_ok = first_ff ? buf_ready
                            : buf_ready & ~wp_lat_ff & ~rej_ff;
    wire byte_ack = addr_ph_ff ? addr_ok : data_ok;
    wire push = byte_end & ~addr_ph_ff & data_ok;
    wire pop = head_v_ff & i_rx_ready;
    wire load_tx = scl_fall & ((st_ff == S_ACK & ack_ff & rd_ff)
                               | st_ff == S_RACK);
    // program on STOP after accepted data
    wire prog_go = stop_ev & wrote_ff & ~rej_ff & ~busy_ff;
    wire prog_end = busy_ff & prog_cnt_ff == PROGRAM_LIMIT - 1'b1;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sync1_ff <= LINE_RST;
            sync2_ff <= LINE_RST;
        end else begin
            sync1_ff <= {i_sda, i_scl};
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            filt_ff <= LINE_RST;
            filt_d_ff <= LINE_RST;
            fcnt_ff[0] <= '0;
            fcnt_ff[1] <= '0;
        end else begin
            filt_d_ff <= filt_ff;
            for (int i = 0; i < 2; i++) begin
                if (sync2_ff[i] == filt_ff[i]) begin
                    fcnt_ff[i] <= '0;
                end else if (fcnt_ff[i] == FILTER_LIMIT) begin
                    filt_ff[i] <= sync2_ff[i];
                    fcnt_ff[i] <= '0;
                end else begin
                    fcnt_ff[i] <= fcnt_ff[i] + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            up_cnt_ff <= '0;
            ready_ff <= 1'b0;
        end else if (!ready_ff) begin
            up_cnt_ff <= up_cnt_ff + 21'h00_0001;
            ready_ff <= up_cnt_ff == POWERUP_LIMIT - 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            busy_ff <= 1'b0;
            prog_cnt_ff <= '0;
        end else begin
            busy_ff <= prog_go | (busy_ff & ~prog_end);
            prog_cnt_ff <= busy_ff ? prog_cnt_ff + 21'h00_0001 : '0;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_bit = bit_ff;
        nxt_shift = shift_ff;
        nxt_tx = tx_ff;
        nxt_oe_n = oe_n_ff;
        nxt_ack = ack_ff;
        nxt_addr_ph = addr_ph_ff;
        nxt_first = first_ff;
        nxt_rd = rd_ff;
        nxt_wp = wp_lat_ff;
        nxt_rej = rej_ff;
        nxt_wrote = wrote_ff;
        nxt_sel = sel_ff;
        if (stop_ev) begin
            nxt_st = S_IDLE;
            nxt_oe_n = 1'b1;
            nxt_wrote = 1'b0;
        // only a START wakes the device
        end else if (start_ev) begin
            nxt_st = S_RECV;
            nxt_bit = '0;
            nxt_oe_n = 1'b1;
            nxt_addr_ph = 1'b1;
        end else begin
            unique case (st_ff)
                S_IDLE, S_IGNORE: begin
                end
                S_RECV: begin
                    // shift in on rise, MSB first
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda};
                        nxt_bit = bit_ff + 4'h1;
                    // ack driven through the ninth clock
                    end else if (byte_end) begin
                        nxt_st = S_ACK;
                        nxt_ack = byte_ack;
                        nxt_oe_n = ~byte_ack;
                        if (addr_ph_ff) begin
                            nxt_sel = shift_ff[ADDR_SEL_MSB:ADDR_RW_BIT];
                            nxt_rd = shift_ff[ADDR_RW_BIT];
                            nxt_first = ~shift_ff[ADDR_RW_BIT];
                            nxt_rej = 1'b0;
                        end else if (!first_ff) begin
                            nxt_wrote = wrote_ff | data_ok;
                            nxt_rej = rej_ff | wp_lat_ff;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        nxt_addr_ph = 1'b0;
                        nxt_bit = '0;
                        if (!ack_ff) begin
                            nxt_st = S_IGNORE;
                            nxt_oe_n = 1'b1;
                        end else if (rd_ff) begin
                            nxt_st = S_SEND;
                            nxt_tx = i_rd_data;
                            nxt_oe_n = i_rd_data[7];
                        end else begin
                            nxt_st = S_RECV;
                            nxt_oe_n = 1'b1;
                            nxt_wp = wp2_ff;
                            nxt_first = first_ff & addr_ph_ff;
                        end
                    end
                end
                S_SEND: begin
                    // drive low or release on fall
                    if (scl_fall) begin
                        nxt_bit = bit_ff + 4'h1;
                        nxt_tx = {tx_ff[6:0], 1'b0};
                        nxt_oe_n = bit_ff == LAST_TX_BIT | tx_ff[6];
                        if (bit_ff == LAST_TX_BIT) begin
                            nxt_st = S_RACK;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise && sda) begin
                        nxt_st = S_IGNORE;
                    end else if (scl_fall) begin
                        nxt_st = S_SEND;
                        nxt_bit = '0;
                        nxt_tx = i_rd_data;
                        nxt_oe_n = i_rd_data[7];
                    end
                end
                default: begin
                    nxt_st = S_IDLE;
                    nxt_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            st_ff <= S_IDLE;
            bit_ff <= '0;
            shift_ff <= BYTE_RST;
            tx_ff <= BYTE_RST;
            oe_n_ff <= 1'b1;
            ack_ff <= 1'b0;
            addr_ph_ff <= 1'b0;
            first_ff <= 1'b0;
            rd_ff <= 1'b0;
            wp_lat_ff <= 1'b0;
            rej_ff <= 1'b0;
            wrote_ff <= 1'b0;
            sel_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            bit_ff <= nxt_bit;
            shift_ff <= nxt_shift;
            tx_ff <= nxt_tx;
            oe_n_ff <= nxt_oe_n;
            ack_ff <= nxt_ack;
            addr_ph_ff <= nxt_addr_ph;
            first_ff <= nxt_first;
            rd_ff <= nxt_rd;
            wp_lat_ff <= nxt_wp;
            rej_ff <= nxt_rej;
            wrote_ff <= nxt_wrote;
            sel_ff <= nxt_sel;
        end
    end

    // two-entry receive buffer, full means nack
    always_comb begin
        nxt_head = head_ff;
        nxt_head_v = head_v_ff;
        nxt_tail = tail_ff;
        nxt_tail_v = tail_v_ff;
        if (pop) begin
            nxt_head = tail_ff;
            nxt_head_v = tail_v_ff;
            nxt_tail_v = 1'b0;
        end
        if (push) begin
            if (!nxt_head_v) begin
                nxt_head = {first_ff, shift_ff};
                nxt_head_v = 1'b1;
            end else begin
                nxt_tail = {first_ff, shift_ff};
                nxt_tail_v = 1'b1;
            end
        end
    end

    // pull-down always enabled on inhibit pin
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            head_ff <= '0;
            tail_ff <= '0;
            head_v_ff <= 1'b0;
            tail_v_ff <= 1'b0;
            wp1_ff <= 1'b0;
            wp2_ff <= 1'b0;
            rd_req_ff <= 1'b0;
            sda_o_ff <= 1'b0;
            pd_ff <= 1'b0;
        end else begin
            head_ff <= nxt_head;
            tail_ff <= nxt_tail;
            head_v_ff <= nxt_head_v;
            tail_v_ff <= nxt_tail_v;
            wp1_ff <= i_wp;
            wp2_ff <= wp1_ff;
            rd_req_ff <= load_tx & ~stop_ev & ~start_ev;
            sda_o_ff <= 1'b0;
            pd_ff <= 1'b0;
        end
    end

    assign o_sda_o = sda_o_ff;
    assign o_sda_oe_n = oe_n_ff;
    assign o_wp_pd_oe_n = pd_ff;
    assign o_ready = ready_ff;
    assign o_busy = busy_ff;
    assign o_wr_reject = rej_ff;
    assign o_sel = sel_ff;
    assign o_rx_valid = head_v_ff;
    assign o_rx_word = head_ff;
    assign o_rd_req = rd_req_ff;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    sequence byte_end_s;
        byte_end;
    endsequence
    sequence addr_acked_s;
        st_ff == S_ACK && addr_ph_ff && ack_ff;
    endsequence

    AST_SILENT_NOT_READY: assert property (
        !ready_ff |-> o_sda_oe_n && st_ff == S_IDLE)
        else $error("device active before power-up ready");
    AST_READY_TIME: assert property (
        $rose(ready_ff) |-> $past(up_cnt_ff) == POWERUP_LIMIT - 1'b1)
        else $error("ready asserted at wrong time");
    AST_FILTER_HOLD: assert property (
        $changed(filt_ff[LINE_SDA]) |-> $past(fcnt_ff[1]) == FILTER_LIMIT)
        else $error("sda filter passed a short pulse");
    AST_DRIVE_ON_FALL: assert property (
        $fell(o_sda_oe_n) |-> $past(scl_fall))
        else $error("sda drive started outside scl fall");
    AST_OPEN_DRAIN: assert property (
        !o_sda_oe_n |-> !o_sda_o)
        else $error("sda driven high");
    AST_STOP_IDLE: assert property (
        stop_ev |=> st_ff == S_IDLE && o_sda_oe_n)
        else $error("stop did not return to idle");
    AST_NINTH_ACK: assert property (
        byte_end_s |=> st_ff == S_ACK && o_sda_oe_n == !ack_ff)
        else $error("ack phase not entered after eight bits");
    AST_TYPE_MATCH: assert property (
        addr_acked_s |-> shift_ff[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEVICE_TYPE
                         && sel_ff.read == shift_ff[ADDR_RW_BIT])
        else $error("address acked without type match");
    AST_BUSY_NACK: assert property (
        addr_acked_s |-> !busy_ff)
        else $error("address acked during programming");
    AST_WP_REFUSE: assert property (
        byte_end_s ##0 (!addr_ph_ff && !first_ff && wp_lat_ff)
        |=> !ack_ff && rej_ff ##1 !prog_go)
        else $error("inhibited data byte acked");
    AST_PROG_BOUND: assert property (
        busy_ff |-> prog_cnt_ff < PROGRAM_LIMIT)
        else $error("programming exceeded limit");
endmodule

// *** core/eeprom_front_pkg.sv ***
package eeprom_front_pkg;
    localparam int MCLK_PERIOD_NS = 4;
    localparam int INPUT_GLITCH_FILTER_WIDTH_NS = 100;
    localparam int POWERUP_READY_DELAY_MS = 1;
    localparam int INTERNAL_PROGRAM_TIME_MS = 5;
    localparam int FILTER_CYCLES =
        INPUT_GLITCH_FILTER_WIDTH_NS / MCLK_PERIOD_NS;
    localparam int POWERUP_CYCLES =
        POWERUP_READY_DELAY_MS * 1_000_000 / MCLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES =
        INTERNAL_PROGRAM_TIME_MS * 1_000_000 / MCLK_PERIOD_NS;
    localparam int TIMER_W = 21;
    localparam int FILT_W = 8;
    // arbitrary device-type code
    localparam logic [3:0] DEVICE_TYPE_DEF = 4'h5;
    localparam int ADDR_TYPE_MSB = 7;
    localparam int ADDR_TYPE_LSB = 4;
    localparam int ADDR_SEL_MSB = 3;
    localparam int ADDR_RW_BIT = 0;
    localparam int LINE_SCL = 0;
    localparam int LINE_SDA = 1;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] LINE_RST = 2'h3;

    typedef enum logic [2:0] {
        S_IDLE, S_RECV, S_ACK, S_SEND, S_RACK, S_IGNORE
    } proto_state_t;

    typedef struct packed {
        logic spare;
        logic array_address_bit_high;
        logic array_address_bit_low;
        logic read;
    } select_t;

    typedef struct packed {
        logic word_addr;
        logic [7:0] data;
    } rx_word_t;
endpackage

// *** test/two_wire_master.sv ***
module two_wire_master (
    input wire logic i_mclk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // quarter of the 160 ns link period
    task automatic q();
        repeat (10) @(negedge i_mclk);
    endtask
    // change while low, sample while high
    task automatic bit_clk(input logic b, output logic r);
        q();
        o_sda_pull = ~b;
        q();
        o_scl = 1'b1;
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
    endtask
    // begin from idle or repeated start
    task automatic start();
        if (!o_scl) begin
            q();
            o_sda_pull = 1'b0;
            q();
            o_scl = 1'b1;
        end
        q();
        o_sda_pull = 1'b1;
        q();
        o_scl = 1'b0;
    endtask
    task automatic stop();
        q();
        o_sda_pull = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda_pull = 1'b0;
        q();
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_clk(b[i], r);
        bit_clk(1'b1, r);
        ack = ~r;
    endtask
    // answer the device on ninth clock
    task automatic recv(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(1'b1, r);
            b[i] = r;
        end
        bit_clk(~ack, r);
    endtask
    // short spike on a low clock
    task automatic glitch();
        @(negedge i_mclk);
        o_scl = 1'b1;
        repeat (2) @(negedge i_mclk);
        o_scl = 1'b0;
    endtask
endmodule

// *** test/eeprom_front_bench.sv ***
module eeprom_front_bench;
    import eeprom_front_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [20:0] PROG = 21'h0_07d0;
    logic mclk = 1'b0, reset = 1'b1, rx_ready = 1'b0, stall = 1'b0;
    logic wp_en = 1'b0, wp_drv = 1'b0, scl, pull, ack;
    logic sda_o, sda_oe_n, wp_pd_oe_n, ready, busy, wr_reject;
    logic rx_valid, rd_req;
    logic [7:0] rd_tab [16], b;
    select_t sel;
    rx_word_t rx_word, exp_q [$];
    int rd_ptr = 0, rd_n = 0, n_errors = 0, n_checks = 0;
    wire sda_line = ~(pull | ~sda_oe_n);
    wire wp_pin = wp_en ? wp_drv : wp_pd_oe_n;
    wire [7:0] rd_data = rd_tab[rd_ptr[3:0]];
    eeprom_front #(.POWERUP_LIMIT(21'h0_0014), .PROGRAM_LIMIT(PROG),
        .FILTER_LIMIT(8'h04)) DUT (.i_mclk(mclk), .i_reset(reset),
        .i_scl(scl), .i_sda(sda_line), .i_wp(wp_pin),
        .i_rx_ready(rx_ready), .i_rd_data(rd_data), .o_sda_o(sda_o),
        .o_sda_oe_n(sda_oe_n), .o_wp_pd_oe_n(wp_pd_oe_n), .o_ready(ready),
        .o_busy(busy), .o_wr_reject(wr_reject), .o_sel(sel),
        .o_rx_valid(rx_valid), .o_rx_word(rx_word), .o_rd_req(rd_req));
    two_wire_master m (.i_mclk(mclk), .i_sda(sda_line), .o_scl(scl),
        .o_sda_pull(pull));
    always #2 mclk = ~mclk;
    always @(negedge mclk) begin
        rx_ready <= stall ? 1'b0 : 1'($urandom);
        if (rd_req === 1'b1) rd_ptr <= rd_ptr + 1;
    end
    task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge mclk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0) check("rx extra", rx_word, 9'h1_ff);
            else check("rx word", rx_word, exp_q.pop_front());
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_low(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'b0; i++) @(negedge mclk);
    endtask
    task automatic write_frame(int n, int n_ok, logic wp);
        logic [7:0] d;
        m.start();
        m.send({DEVICE_TYPE_DEF, 4'h0}, ack);
        check("addr ack", ack, 1);
        wp_en = wp;
        wp_drv = wp;
        d = 8'($urandom);
        // note before sending: the word may pop before send returns
        exp_q.push_back({1'b1, d});
        m.send(d, ack);
        check("word ack", ack, 1);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (i < n_ok) exp_q.push_back({1'b0, d});
            m.send(d, ack);
            check("data ack", ack, 9'(i < n_ok));
            if (i >= n_ok) break;
        end
        m.stop();
        repeat (3) @(negedge mclk);
        check("reject", wr_reject, 9'(wp));
        check("busy", busy, 9'(n_ok > 0));
        wp_en = 1'b0;
    endtask
    initial begin
        #400_000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(60));
        foreach (rd_tab[i]) rd_tab[i] = 8'($urandom);
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        repeat (2) @(negedge mclk);
        check("ready early", ready, 0);
        check("sda oe", sda_oe_n, 1);
        check("wp pulldown", wp_pd_oe_n, 0);
        check("sda out", sda_o, 0);
        for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge mclk);
        check("ready", ready, 1);
        for (int k = 0; k < 16; k++) begin
            m.start();
            // spike must not count as a clock
            if (k == 0) m.glitch();
            m.send({DEVICE_TYPE_DEF, 4'(k)}, ack);
            check("sel ack", ack, 1);
            check("sel", sel, 9'(k));
            for (int j = 0; k[0] && j < (k == 15 ? 2 : 1); j++) begin
                m.recv(k == 15 && j == 0, b);
                check("rd data", b, rd_tab[rd_n]);
                rd_n++;
            end
            m.stop();
        end
        m.start();
        m.send({~DEVICE_TYPE_DEF, 4'h0}, ack);
        check("foreign ack", ack, 0);
        m.send(8'h5a, ack);
        check("ignored ack", ack, 0);
        m.stop();
        write_frame(2, 2, 1'b0);
        m.start();
        m.send({DEVICE_TYPE_DEF, 4'h0}, ack);
        check("busy ack", ack, 0);
        m.stop();
        wait_low(busy, 2100);
        check("busy end", busy, 0);
        write_frame(1, 0, 1'b1);
        stall = 1'b1;
        write_frame(2, 1, 1'b0);
        check("buffer full", rx_valid, 1);
        stall = 1'b0;
        wait_low(busy, 2100);
        wait_low(rx_valid, 100);
        check("drained", 9'(exp_q.size()), 0);
        stall = 1'b1;
        m.start();
        m.send({DEVICE_TYPE_DEF, 4'h2}, ack);
        m.send(8'h33, ack);
        @(negedge mclk);
        reset = 1'b1;
        repeat (3) @(negedge mclk);
        check("rst valid", rx_valid, 0);
        check("rst sel", sel, 0);
        check("rst oe", sda_oe_n, 1);
        reset = 1'b0;
        stall = 1'b0;
        m.stop();
        write_frame(1, 1, 1'b0);
        wait_low(busy, 2100);
        wait_low(rx_valid, 100);
        check("final queue", 9'(exp_q.size()), 0);
        report_and_stop();
    end
endmodule
